// ---- verilog/iexp_pkg.sv ----
package iexp_pkg;
  localparam logic [3:0] ADDR_FIXED = 4'h4;
  localparam logic [6:0] ADDR_GENERAL_CALL = 7'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] TX_LAST_BIT = 3'h7;
  localparam logic [7:0] PORT_RESET = 8'hff;
  localparam logic [1:0] BUS_RESET = 2'h3;
  localparam logic [2:0] STRAP_RESET = 3'h0;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_ADDR_ACK = 8'h04,
    ST_WR_DATA = 8'h08,
    ST_WR_ACK = 8'h10,
    ST_RD_DATA = 8'h20,
    ST_RD_ACK = 8'h40,
    ST_IGNORE = 8'h80
  } iexp_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } iexp_bus_s;

  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
  } iexp_evt_s;
endpackage

// ---- verilog/iexp_sync.sv ----
`timescale 1ns/100ps
module iexp_sync import iexp_pkg::*; #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // raw and filtered levels
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] filt_out
);
  logic [WIDTH-1:0] ff1_q, ff2_q, ff3_q, filt_q;
  logic [WIDTH-1:0] filt_d;

  // a level moves only once the second and third stages agree
  always_comb begin
    filt_d = (ff2_q & ff3_q) | (filt_q & (ff2_q | ff3_q));
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ff1_q <= RST_VAL;
      ff2_q <= RST_VAL;
      ff3_q <= RST_VAL;
      filt_q <= RST_VAL;
    end else begin
      ff1_q <= raw_in;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      filt_q <= filt_d;
    end
  end

  assign filt_out = filt_q;
endmodule // iexp_sync

// ---- verilog/iexp_cond.sv ----
`timescale 1ns/100ps
module iexp_cond import iexp_pkg::*; (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // filtered bus levels and decoded events
  input wire iexp_bus_s bus_in,
  output iexp_evt_s evt_out
);
  iexp_bus_s prev_q, prev_d;
  iexp_evt_s evt;

  always_comb begin
    prev_d = bus_in;
    // sda moving while scl stays high is a bus condition
    evt.start = prev_q.scl & bus_in.scl & prev_q.sda & ~bus_in.sda;
    evt.stop = prev_q.scl & bus_in.scl & ~prev_q.sda & bus_in.sda;
    evt.scl_rise = ~prev_q.scl & bus_in.scl;
    evt.scl_fall = prev_q.scl & ~bus_in.scl;
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      prev_q <= BUS_RESET;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign evt_out = evt;
endmodule // iexp_cond

// ---- verilog/iexp_target.sv ----
`timescale 1ns/100ps
module iexp_target import iexp_pkg::*; (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // serial bus, sda as three signals
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // address straps
  input wire logic addr_strap_lsb_in,
  input wire logic addr_strap_mid_in,
  input wire logic addr_strap_msb_in,
  // ports
  input wire logic [7:0] port_low_pins_in,
  input wire logic [7:0] port_high_pins_in,
  output logic [7:0] port_low_pins_out,
  output logic [7:0] port_high_pins_out
);
  iexp_bus_s bus;
  iexp_evt_s evt;
  logic [2:0] strap;
  logic [15:0] pins;

  iexp_state_e state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] pend_q, pend_d;
  logic sel_q, sel_d;
  logic rw_q, rw_d;
  logic oe_q, oe_d;
  logic drv_q;
  logic [7:0] lo_q, lo_d, hi_q, hi_d;
  logic addr_match;

  iexp_sync #(.WIDTH(2), .RST_VAL(BUS_RESET)) u_bus_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .raw_in({scl_in, sda_in}),
    .filt_out(bus)
  );

  // straps and pins are synchronised too; straps are assumed steady in a frame
  iexp_sync #(.WIDTH(19), .RST_VAL({STRAP_RESET, PORT_RESET, PORT_RESET})) u_pin_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .raw_in({addr_strap_msb_in, addr_strap_mid_in, addr_strap_lsb_in,
             port_high_pins_in, port_low_pins_in}),
    .filt_out({strap, pins})
  );

  iexp_cond u_cond (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .bus_in(bus),
    .evt_out(evt)
  );

  // general call can never carry the fixed nibble, but is refused explicitly
  assign addr_match = (sh_q[7:1] == {ADDR_FIXED, strap}) &&
                      (sh_q[7:1] != ADDR_GENERAL_CALL);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    pend_d = pend_q;
    sel_d = sel_q;
    rw_d = rw_q;
    oe_d = oe_q;
    lo_d = lo_q;
    hi_d = hi_q;
    if (evt.stop) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (evt.start) begin
      // a repeated start drops the byte in flight
      state_d = ST_ADDR;
      cnt_d = 4'h0;
      sel_d = 1'b0;
      oe_d = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          oe_d = 1'b0;
        end
        ST_ADDR: begin
          if (evt.scl_rise) begin
            sh_d = {sh_q[6:0], bus.sda};
            cnt_d = cnt_q + 4'h1;
          end else if (evt.scl_fall && cnt_q == BITS_PER_BYTE) begin
            rw_d = sh_q[0];
            if (addr_match) begin
              state_d = ST_ADDR_ACK;
              oe_d = 1'b1;
            end else begin
              state_d = ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (evt.scl_fall) begin
            cnt_d = 4'h0;
            if (rw_q) begin
              state_d = ST_RD_DATA;
              sh_d = pins[7:0];
              sel_d = 1'b1;
              oe_d = ~pins[7];
            end else begin
              state_d = ST_WR_DATA;
              oe_d = 1'b0;
            end
          end
        end
        ST_WR_DATA: begin
          if (evt.scl_rise) begin
            sh_d = {sh_q[6:0], bus.sda};
            cnt_d = cnt_q + 4'h1;
          end else if (evt.scl_fall && cnt_q == BITS_PER_BYTE) begin
            state_d = ST_WR_ACK;
            oe_d = 1'b1;
          end
        end
        ST_WR_ACK: begin
          if (evt.scl_rise) begin
            sel_d = ~sel_q;
            if (sel_q) begin
              lo_d = pend_q;
              hi_d = sh_q;
            end else begin
              pend_d = sh_q;
            end
          end else if (evt.scl_fall) begin
            // ack stays low until scl falls again
            state_d = ST_WR_DATA;
            cnt_d = 4'h0;
            oe_d = 1'b0;
          end
        end
        ST_RD_DATA: begin
          if (evt.scl_fall) begin
            if (cnt_q[2:0] == TX_LAST_BIT) begin
              state_d = ST_RD_ACK;
              oe_d = 1'b0;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              cnt_d = cnt_q + 4'h1;
              oe_d = ~sh_q[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (evt.scl_rise) begin
            rw_d = ~bus.sda;
            if (bus.sda) begin
              state_d = ST_IGNORE;
            end
          end else if (evt.scl_fall && rw_q) begin
            state_d = ST_RD_DATA;
            cnt_d = 4'h0;
            sh_d = sel_q ? pins[15:8] : pins[7:0];
            oe_d = sel_q ? ~pins[15] : ~pins[7];
            sel_d = ~sel_q;
          end
        end
        ST_IGNORE: begin
          oe_d = 1'b0;
        end
        default: begin
          state_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // ports power up high, serial logic idles
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      pend_q <= PORT_RESET;
      sel_q <= 1'b0;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
      drv_q <= 1'b0;
      lo_q <= PORT_RESET;
      hi_q <= PORT_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      pend_q <= pend_d;
      sel_q <= sel_d;
      rw_q <= rw_d;
      oe_q <= oe_d;
      drv_q <= 1'b0;
      lo_q <= lo_d;
      hi_q <= hi_d;
    end
  end

  // open drain: the driven level is always low
  assign sda_out = drv_q;
  assign sda_oe_out = oe_q;
  assign port_low_pins_out = lo_q;
  assign port_high_pins_out = hi_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  property p_stop_idle;
    evt.stop |=> state_q == ST_IDLE && !oe_q;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not return to idle");

  property p_start_addr;
    evt.start && !evt.stop |=> state_q == ST_ADDR && cnt_q == 4'h0 && !oe_q;
  endproperty
  a_start_addr: assert property (p_start_addr)
    else $error("start did not restart address reception");

  property p_general_call;
    state_q == ST_ADDR && evt.scl_fall && !evt.start && !evt.stop &&
      cnt_q == BITS_PER_BYTE && sh_q[7:1] == 7'h00 |=> state_q == ST_IGNORE;
  endproperty
  a_general_call: assert property (p_general_call)
    else $error("general call was answered");

  property p_match_ack;
    state_q == ST_ADDR && evt.scl_fall && !evt.start && !evt.stop &&
      cnt_q == BITS_PER_BYTE && sh_q[7:1] == {ADDR_FIXED, strap}
      |=> state_q == ST_ADDR_ACK && oe_q;
  endproperty
  a_match_ack: assert property (p_match_ack)
    else $error("matching address not acknowledged");

  property p_ack_held;
    (state_q == ST_ADDR_ACK || state_q == ST_WR_ACK) && bus.scl |-> oe_q;
  endproperty
  a_ack_held: assert property (p_ack_held)
    else $error("ack released during high phase");

  property p_quiet;
    state_q == ST_IGNORE || state_q == ST_IDLE || state_q == ST_RD_ACK |-> !oe_q;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("sda driven while it must be released");

  property p_port_update;
    !$stable(port_low_pins_out) || !$stable(port_high_pins_out)
      |-> $past(state_q == ST_WR_ACK && evt.scl_rise && sel_q);
  endproperty
  a_port_update: assert property (p_port_update)
    else $error("port changed outside second write ack");

  property p_pair_commit;
    state_q == ST_WR_ACK && evt.scl_rise && sel_q && !evt.start && !evt.stop
      |=> port_high_pins_out == $past(sh_q) && port_low_pins_out == $past(pend_q);
  endproperty
  a_pair_commit: assert property (p_pair_commit)
    else $error("write pair not committed");

  property p_rd_nack;
    state_q == ST_RD_ACK && evt.scl_rise && bus.sda && !evt.start && !evt.stop
      |=> state_q == ST_IGNORE ##1 !oe_q;
  endproperty
  a_rd_nack: assert property (p_rd_nack)
    else $error("nack did not release sda");

  property p_wr_ack;
    state_q == ST_WR_DATA && evt.scl_fall && !evt.start && !evt.stop &&
      cnt_q == BITS_PER_BYTE |=> state_q == ST_WR_ACK && oe_q;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("received data byte not acknowledged");

  property p_ack_release;
    state_q == ST_WR_ACK && evt.scl_fall && !evt.start && !evt.stop
      |=> state_q == ST_WR_DATA && !oe_q && cnt_q == 4'h0;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("write ack not released for the next byte");

  property p_rd_release;
    state_q == ST_RD_DATA && evt.scl_fall && !evt.start && !evt.stop &&
      cnt_q[2:0] == TX_LAST_BIT |=> state_q == ST_RD_ACK && !oe_q;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("sda not released after the eighth read bit");

  // the first read bit must mirror port low pin 7 as it stood at the ack fall
  property p_rd_first;
    state_q == ST_ADDR_ACK && rw_q && evt.scl_fall && !evt.start && !evt.stop
      |=> state_q == ST_RD_DATA && oe_q == ~$past(pins[7]);
  endproperty
  a_rd_first: assert property (p_rd_first)
    else $error("first read bit does not follow the port pin");

  c_write_pair: cover property (state_q == ST_WR_ACK && evt.scl_rise && sel_q);
  c_read_byte: cover property (state_q == ST_RD_ACK && evt.scl_rise && !bus.sda);
  c_read_nack: cover property (state_q == ST_RD_ACK && evt.scl_rise && bus.sda);
  c_rep_start: cover property (evt.start && state_q != ST_IDLE);
  c_reject: cover property (state_q == ST_ADDR && evt.scl_fall && cnt_q == BITS_PER_BYTE &&
    !addr_match);
endmodule // iexp_target

// ---- bench/iexp_ctl_model.sv ----
`timescale 1ns/100ps
module iexp_ctl_model (
  // clock
  input wire logic clock_in,
  // serial bus, sda as released-high drive
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  localparam int HALF = 10;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // lines move only just after an edge and hold for n clocks
  task automatic drv(input logic c, input logic d, input int n);
    @(posedge clock_in);
    scl_out <= c;
    sda_out <= d;
    repeat (n - 1) @(posedge clock_in);
  endtask
  // also a repeated start when called mid-frame with scl low
  task automatic start;
    drv(scl_out, 1'b1, HALF);
    drv(1'b1, 1'b1, HALF);
    drv(1'b1, 1'b0, HALF);
    drv(1'b0, 1'b0, HALF / 2);
  endtask
  task automatic stop;
    drv(1'b0, 1'b0, HALF / 2);
    drv(1'b1, 1'b0, HALF);
    drv(1'b1, 1'b1, HALF);
  endtask
  // sda moves mid-low, sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    drv(1'b0, b, HALF / 2);
    drv(1'b1, b, HALF);
    r = sda_in;
    drv(1'b0, b, HALF / 2);
  endtask
  task automatic byte_w(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, nack);
  endtask
  task automatic byte_r(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // iexp_ctl_model

// ---- bench/iexp_target_tb.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module iexp_target_tb;
  logic clock_in, rst_in, scl, ctl_sda, sda_out, sda_oe_out, nk;
  logic [2:0] strap;
  logic [7:0] p_low_in, p_high_in, p_low_out, p_high_out, rd;
  wire logic sda_wire;
  int err_total, cmp_count;
  // pull-up plus wired-and of both open-drain drivers
  assign sda_wire = ctl_sda & ~(sda_oe_out & ~sda_out);
  iexp_ctl_model iexp_ctl_model_i (.clock_in(clock_in), .sda_in(sda_wire),
    .scl_out(scl), .sda_out(ctl_sda));
  iexp_target iexp_target_i (.clock_in(clock_in), .rst_in(rst_in), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .addr_strap_lsb_in(strap[0]), .addr_strap_mid_in(strap[1]),
    .addr_strap_msb_in(strap[2]), .port_low_pins_in(p_low_in),
    .port_high_pins_in(p_high_in), .port_low_pins_out(p_low_out),
    .port_high_pins_out(p_high_out));
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic ports(input logic [7:0] lo, input logic [7:0] hi);
    `CHK(p_low_out, lo)
    `CHK(p_high_out, hi)
  endtask
  task automatic wr(input logic [7:0] d);
    iexp_ctl_model_i.byte_w(d, nk);
    `CHK(nk, 1'b0)
  endtask
  task automatic t_reset;
    ports(8'hff, 8'hff);
    `CHK(sda_oe_out, 1'b0)
  endtask
  task automatic t_straps;
    for (int s = 0; s < 8; s++) begin
      @(posedge clock_in);
      strap <= s[2:0];
      repeat (6) @(posedge clock_in);
      iexp_ctl_model_i.start();
      wr({4'h4, s[2:0], 1'b0});
      wr({s[3:0], ~s[3:0]});
      wr({~s[3:0], s[3:0]});
      iexp_ctl_model_i.stop();
      ports({s[3:0], ~s[3:0]}, {~s[3:0], s[3:0]});
    end
  endtask
  // strap is 7 from here on, write address 4e
  task automatic t_pairs;
    iexp_ctl_model_i.start();
    wr(8'h4e);
    wr(8'h5a);
    ports(8'h78, 8'h87);
    wr(8'hc3);
    ports(8'h5a, 8'hc3);
    wr(8'h33);
    wr(8'h44);
    ports(8'h33, 8'h44);
    wr(8'h0f);
    for (int i = 0; i < 3; i++) iexp_ctl_model_i.bit_io(1'b0, nk);
    iexp_ctl_model_i.stop();
    ports(8'h33, 8'h44);
  endtask
  task automatic t_read;
    @(posedge clock_in);
    p_low_in <= 8'ha5;
    p_high_in <= 8'h3c;
    repeat (6) @(posedge clock_in);
    iexp_ctl_model_i.start();
    wr(8'h4f);
    iexp_ctl_model_i.byte_r(1'b0, rd);
    `CHK(rd, 8'ha5)
    iexp_ctl_model_i.byte_r(1'b0, rd);
    `CHK(rd, 8'h3c)
    iexp_ctl_model_i.byte_r(1'b1, rd);
    `CHK(rd, 8'ha5)
    `CHK(sda_oe_out, 1'b0)
    iexp_ctl_model_i.stop();
  endtask
  task automatic t_reject;
    logic [7:0] bad [3] = '{8'h00, 8'h4c, 8'h6e};
    foreach (bad[k]) begin
      iexp_ctl_model_i.start();
      iexp_ctl_model_i.byte_w(bad[k], nk);
      `CHK(nk, 1'b1)
      iexp_ctl_model_i.byte_w(8'h00, nk);
      `CHK(nk, 1'b1)
      iexp_ctl_model_i.stop();
      ports(8'h33, 8'h44);
    end
  endtask
  task automatic t_restart;
    iexp_ctl_model_i.start();
    wr(8'h4e);
    wr(8'h77);
    for (int i = 0; i < 4; i++) iexp_ctl_model_i.bit_io(1'b1, nk);
    iexp_ctl_model_i.start();
    wr(8'h4e);
    wr(8'h12);
    wr(8'h34);
    ports(8'h12, 8'h34);
    iexp_ctl_model_i.stop();
  endtask
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  // whole run needs about 10000 clocks
  initial begin
    repeat (30000) @(posedge clock_in);
    err_total++;
    results();
  end
  initial begin
    rst_in = 1'b1;
    strap = 3'h0;
    p_low_in = 8'hff;
    p_high_in = 8'hff;
    err_total = 0;
    cmp_count = 0;
    repeat (5) @(posedge clock_in);
    t_reset();
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    t_reset();
    t_straps();
    t_pairs();
    t_read();
    t_reject();
    t_restart();
    results();
  end
endmodule // iexp_target_tb
